// file: logic/ldorc_params.svh
// constants for the regulator control register bank
`ifndef LDORC_PARAMS_SVH
`define LDORC_PARAMS_SVH

`define LDORC_NUM_CH        3
`define LDORC_ADDR_W        8
`define LDORC_DATA_W        32
`define LDORC_BYTE_W        8
`define LDORC_ADDR_A_VOLT   8'h54
`define LDORC_ADDR_A_CTRL   8'h55
`define LDORC_ADDR_B_VOLT   8'h60
`define LDORC_ADDR_B_CTRL   8'h61
`define LDORC_ADDR_C_VOLT   8'h64
`define LDORC_ADDR_C_CTRL   8'h65
`define LDORC_BIT_ENABLE    7
`define LDORC_BIT_DISCH     6
`define LDORC_BIT_LOW_QUIESCENT_SELECT     5
`define LDORC_DLY_HI        4
`define LDORC_DLY_LO        2
`define LDORC_BIT_FLTEN     1
`define LDORC_BIT_PGOOD     0
`define LDORC_OUTPUT_VOLTAGE_CODE_HI       5
`define LDORC_OUTPUT_VOLTAGE_CODE_W        6
`define LDORC_DLY_W         3
`define LDORC_OUTPUT_VOLTAGE_CODE_RST      6'h00
`define LDORC_DLY_RST       3'h0
`define LDORC_UNMAPPED_RD   32'h0000_0000

`endif

// file: logic/ldorc_pkg.sv
// types shared by the regulator control register bank
`include "ldorc_params.svh"
package ldorc_pkg;
    typedef logic [`LDORC_ADDR_W-1:0] ldorc_addr_t;
    typedef logic [`LDORC_DATA_W-1:0] ldorc_data_t;
    typedef logic [`LDORC_NUM_CH-1:0] ldorc_chvec_t;
    typedef struct packed {
        logic                     enable;
        logic                     dischEn;
        logic                     low_quiescent_select;
        logic [`LDORC_DLY_W-1:0]  delayCode;
        logic                     faultIntEn;
        logic [`LDORC_OUTPUT_VOLTAGE_CODE_W-1:0] voltCode;
    } ldorc_chan_t;
    typedef enum logic [1:0] {
        LDORC_IDLE,
        LDORC_ANSWER,
        LDORC_DONE
    } ldorc_bus_state_t;
endpackage

// file: logic/ldorc_sync_if.sv
// interface carrying raw and synchronised regulator status between modules
`timescale 1ns/1ps
`default_nettype none
`include "ldorc_params.svh"
interface ldorc_sync_if;
    logic [`LDORC_NUM_CH-1:0] pgoodRaw;
    logic [`LDORC_NUM_CH-1:0] faultRaw;
    logic [`LDORC_NUM_CH-1:0] pgoodSync;
    logic [`LDORC_NUM_CH-1:0] faultSync;
    modport sync (input pgoodRaw, input faultRaw, output pgoodSync, output faultSync);
    modport user (output pgoodRaw, output faultRaw, input pgoodSync, input faultSync);
endinterface
`default_nettype wire

// file: logic/ldorc_sync.sv
// two-stage synchronisers for analog power-good and fault comparators
`timescale 1ns/1ps
`default_nettype none
`include "ldorc_params.svh"
module ldorc_sync (
    input  wire logic    clk_sys,
    input  wire logic    rst_n,
    ldorc_sync_if.sync   syncIf
);
    logic [`LDORC_NUM_CH-1:0] pgMeta_r;
    logic [`LDORC_NUM_CH-1:0] pgMeta_nxt;
    logic [`LDORC_NUM_CH-1:0] pgSafe_r;
    logic [`LDORC_NUM_CH-1:0] pgSafe_nxt;
    logic [`LDORC_NUM_CH-1:0] ftMeta_r;
    logic [`LDORC_NUM_CH-1:0] ftMeta_nxt;
    logic [`LDORC_NUM_CH-1:0] ftSafe_r;
    logic [`LDORC_NUM_CH-1:0] ftSafe_nxt;

    // first stage feeds only the second stage
    always_comb begin
        pgMeta_nxt = syncIf.pgoodRaw;
        pgSafe_nxt = pgMeta_r;
        ftMeta_nxt = syncIf.faultRaw;
        ftSafe_nxt = ftMeta_r;
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            pgMeta_r <= '0;
            pgSafe_r <= '0;
            ftMeta_r <= '0;
            ftSafe_r <= '0;
        end else begin
            pgMeta_r <= pgMeta_nxt;
            pgSafe_r <= pgSafe_nxt;
            ftMeta_r <= ftMeta_nxt;
            ftSafe_r <= ftSafe_nxt;
        end
    end

    assign syncIf.pgoodSync = pgSafe_r;
    assign syncIf.faultSync = ftSafe_r;
endmodule
`default_nettype wire

// file: logic/ldorc_regs.sv
// control and status register bank for three linear regulator channels
// Function
// - control bit 7 turns the regulator on or off; read/write
// - bit 6 set and regulator off drives the 1.5k discharge path
// - bit 5 selects low-power mode when set, normal mode when clear
// - bits 4:2 hold a read/write three-bit turn-on delay code
// - bit 1 lets channel faults raise an interrupt; clear blocks them
// - bit 0 reads 1 while output is above power-good threshold
// - voltage register bits 5:0 hold read/write output voltage code
// - voltage register bits 7:6 are reserved, read-only, writes ignored
// - voltage/control pairs decode at 0x54/55, 0x60/61, 0x64/65
`timescale 1ns/1ps
`default_nettype none
`include "ldorc_params.svh"
module ldorc_regs (
    input  wire logic                clk_sys,
    input  wire logic                rst_n,
    input  wire ldorc_pkg::ldorc_addr_t avs_address,
    input  wire logic                avs_read,
    input  wire logic                avs_write,
    input  wire ldorc_pkg::ldorc_data_t avs_writedata,
    input  wire logic [3:0]          avs_byteenable,
    output var  ldorc_pkg::ldorc_data_t avs_readdata,
    output var  logic                avs_waitrequest,
    output var  logic                avs_response_err,
    input  wire ldorc_pkg::ldorc_chvec_t pgood_comp,
    input  wire ldorc_pkg::ldorc_chvec_t fault_comp,
    output var  ldorc_pkg::ldorc_chvec_t ldo_enable,
    output var  ldorc_pkg::ldorc_chvec_t ldo_discharge,
    output var  ldorc_pkg::ldorc_chvec_t ldo_low_iq,
    output var  logic [3*`LDORC_DLY_W-1:0]  ldo_delay_code,
    output var  logic [3*`LDORC_OUTPUT_VOLTAGE_CODE_W-1:0] ldo_voltage_code,
    output var  logic                fault_irq
);
    import ldorc_pkg::*;

    ldorc_sync_if syncIf ();

    assign syncIf.pgoodRaw = pgood_comp;
    assign syncIf.faultRaw = fault_comp;

    ldorc_sync uSync (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .syncIf  (syncIf)
    );

    ////////////////////////////////////////////////////////////////////////////
    // address decode: channel index and which register of the pair

    function automatic logic [3:0] decodeAddr(input ldorc_addr_t addr);
        // returns {hit, isCtrl, chan[1:0]}
        case (addr)
            `LDORC_ADDR_A_VOLT: decodeAddr = 4'h8;
            `LDORC_ADDR_A_CTRL: decodeAddr = 4'hc;
            `LDORC_ADDR_B_VOLT: decodeAddr = 4'h9;
            `LDORC_ADDR_B_CTRL: decodeAddr = 4'hd;
            `LDORC_ADDR_C_VOLT: decodeAddr = 4'ha;
            `LDORC_ADDR_C_CTRL: decodeAddr = 4'he;
            default:            decodeAddr = 4'h0;
        endcase
    endfunction

    function automatic logic [`LDORC_BYTE_W-1:0] ctrlByte(input ldorc_chan_t c,
                                                           input logic pg);
        ctrlByte = {c.enable, c.dischEn, c.low_quiescent_select, c.delayCode, c.faultIntEn, pg};
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // register state

    ldorc_chan_t      chan_r [`LDORC_NUM_CH];
    ldorc_chan_t      chan_nxt [`LDORC_NUM_CH];
    ldorc_bus_state_t busState_r;
    ldorc_bus_state_t busState_nxt;
    ldorc_data_t      rdData_r;
    ldorc_data_t      rdData_nxt;
    logic             wait_r;
    logic             wait_nxt;
    logic             err_r;
    logic             err_nxt;

    logic [3:0]       dec;
    logic [1:0]       decCh;
    logic [`LDORC_BYTE_W-1:0] wByte;

    assign dec   = decodeAddr(avs_address);
    assign decCh = dec[1:0];
    assign wByte = avs_writedata[`LDORC_BYTE_W-1:0];

    // one wait state: request sampled in IDLE, answered the next cycle
    always_comb begin
        busState_nxt = busState_r;
        rdData_nxt   = rdData_r;
        wait_nxt     = 1'b1;
        err_nxt      = 1'b0;
        for (int i = 0; i < `LDORC_NUM_CH; i++) begin
            chan_nxt[i] = chan_r[i];
        end
        case (busState_r)
            LDORC_IDLE: begin
                if (avs_read || avs_write) begin
                    busState_nxt = LDORC_ANSWER;
                    wait_nxt     = 1'b0;
                    err_nxt      = !dec[3];
                    rdData_nxt   = `LDORC_UNMAPPED_RD;
                    if (avs_read && dec[3]) begin
                        if (dec[2]) begin
                            rdData_nxt[`LDORC_BYTE_W-1:0] =
                                ctrlByte(chan_r[decCh], syncIf.pgoodSync[decCh]);
                        end else begin
                            // reserved bits 7:6 read as zero
                            rdData_nxt[`LDORC_OUTPUT_VOLTAGE_CODE_HI:0] = chan_r[decCh].voltCode;
                        end
                    end
                    // write lands on the edge where waitrequest is seen low
                end
            end
            LDORC_ANSWER: begin
                busState_nxt = LDORC_DONE;
                if (avs_write && dec[3] && avs_byteenable[0]) begin
                    if (dec[2]) begin
                        chan_nxt[decCh].enable     = wByte[`LDORC_BIT_ENABLE];
                        chan_nxt[decCh].dischEn    = wByte[`LDORC_BIT_DISCH];
                        chan_nxt[decCh].low_quiescent_select      = wByte[`LDORC_BIT_LOW_QUIESCENT_SELECT];
                        chan_nxt[decCh].delayCode  =
                            wByte[`LDORC_DLY_HI:`LDORC_DLY_LO];
                        chan_nxt[decCh].faultIntEn = wByte[`LDORC_BIT_FLTEN];
                        // bit 0 is live status; write data there is dropped
                    end else begin
                        // bits 7:6 of write data are dropped
                        chan_nxt[decCh].voltCode = wByte[`LDORC_OUTPUT_VOLTAGE_CODE_HI:0];
                    end
                end
            end
            LDORC_DONE: begin
                // gap cycle lets the master drop its request
                busState_nxt = LDORC_IDLE;
            end
            default: begin
                busState_nxt = LDORC_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            busState_r <= LDORC_IDLE;
            rdData_r   <= '0;
            wait_r     <= 1'b1;
            err_r      <= 1'b0;
            for (int i = 0; i < `LDORC_NUM_CH; i++) begin
                chan_r[i] <= '{1'b0, 1'b0, 1'b0, `LDORC_DLY_RST, 1'b0, `LDORC_OUTPUT_VOLTAGE_CODE_RST};
            end
        end else begin
            busState_r <= busState_nxt;
            rdData_r   <= rdData_nxt;
            wait_r     <= wait_nxt;
            err_r      <= err_nxt;
            for (int i = 0; i < `LDORC_NUM_CH; i++) begin
                chan_r[i] <= chan_nxt[i];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // regulator side outputs, registered

    ldorc_chvec_t enNxt;
    ldorc_chvec_t dischNxt;
    ldorc_chvec_t lowIqNxt;
    logic [3*`LDORC_DLY_W-1:0]  dlyNxt;
    logic [3*`LDORC_OUTPUT_VOLTAGE_CODE_W-1:0] vNxt;
    logic         irqNxt;

    always_comb begin
        irqNxt = 1'b0;
        dlyNxt = '0;
        vNxt   = '0;
        for (int i = 0; i < `LDORC_NUM_CH; i++) begin
            enNxt[i]    = chan_r[i].enable;
            // discharge only while the channel is shut down
            dischNxt[i] = chan_r[i].dischEn && !chan_r[i].enable;
            lowIqNxt[i] = chan_r[i].low_quiescent_select;
            dlyNxt[i*`LDORC_DLY_W +: `LDORC_DLY_W]   = chan_r[i].delayCode;
            vNxt[i*`LDORC_OUTPUT_VOLTAGE_CODE_W +: `LDORC_OUTPUT_VOLTAGE_CODE_W]   = chan_r[i].voltCode;
            // level interrupt: follows the fault while it lasts, no sticky state
            irqNxt = irqNxt || (chan_r[i].faultIntEn && syncIf.faultSync[i]);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ldo_enable       <= '0;
            ldo_discharge    <= '0;
            ldo_low_iq       <= '0;
            ldo_delay_code   <= '0;
            ldo_voltage_code <= '0;
            fault_irq        <= 1'b0;
        end else begin
            ldo_enable       <= enNxt;
            ldo_discharge    <= dischNxt;
            ldo_low_iq       <= lowIqNxt;
            ldo_delay_code   <= dlyNxt;
            ldo_voltage_code <= vNxt;
            fault_irq        <= irqNxt;
        end
    end

    assign avs_readdata     = rdData_r;
    assign avs_waitrequest  = wait_r;
    assign avs_response_err = err_r;
endmodule
`default_nettype wire

// file: tb/ldorc_regs_properties.sv
// port-level assertions for the regulator register bank
`timescale 1ns/1ps
`default_nettype none
`include "ldorc_params.svh"
module ldorc_regs_properties (
    input wire logic                         clk_sys,
    input wire logic                         rst_n,
    input wire ldorc_pkg::ldorc_addr_t       avs_address,
    input wire logic                         avs_read,
    input wire logic                         avs_write,
    input wire ldorc_pkg::ldorc_data_t       avs_writedata,
    input wire logic [3:0]                   avs_byteenable,
    input wire ldorc_pkg::ldorc_data_t       avs_readdata,
    input wire logic                         avs_waitrequest,
    input wire logic                         avs_response_err,
    input wire ldorc_pkg::ldorc_chvec_t      pgood_comp,
    input wire ldorc_pkg::ldorc_chvec_t      fault_comp,
    input wire ldorc_pkg::ldorc_chvec_t      ldo_enable,
    input wire ldorc_pkg::ldorc_chvec_t      ldo_discharge,
    input wire ldorc_pkg::ldorc_chvec_t      ldo_low_iq,
    input wire logic [3*`LDORC_DLY_W-1:0]    ldo_delay_code,
    input wire logic [3*`LDORC_OUTPUT_VOLTAGE_CODE_W-1:0]   ldo_voltage_code,
    input wire logic                         fault_irq
);
    import ldorc_pkg::*;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    logic ans;
    logic mapped;
    logic voltAddr;
    assign ans = !avs_waitrequest && (avs_read || avs_write);
    assign voltAddr = avs_address inside
        {`LDORC_ADDR_A_VOLT, `LDORC_ADDR_B_VOLT, `LDORC_ADDR_C_VOLT};
    assign mapped = voltAddr || avs_address inside
        {`LDORC_ADDR_A_CTRL, `LDORC_ADDR_B_CTRL, `LDORC_ADDR_C_CTRL};
    ////////////////////////////////////////////////////////////////////////
    wait_single_a: assert property ($fell(avs_waitrequest) |=> avs_waitrequest)
        else $error("waitrequest low longer than one cycle");
    read_answer_a: assert property ($rose(avs_read) |-> ##[1:3] !avs_waitrequest)
        else $error("read not answered in time");
    mapped_ok_a: assert property (ans && mapped |-> !avs_response_err)
        else $error("error flagged on a mapped address");
    unmapped_err_a: assert property (ans && !mapped
        |-> avs_response_err && avs_readdata == '0)
        else $error("unmapped access not flagged");
    reserved_zero_a: assert property (ans && avs_read && voltAddr
        |-> avs_readdata[7:6] == 2'h0)
        else $error("reserved voltage bits not zero");
    // sync latency is at most three cycles, so a level held that long must show
    pgood_read_a: assert property (ans && avs_read
        && avs_address == `LDORC_ADDR_A_CTRL && $past(rst_n, 3)
        && $past(pgood_comp[0], 3) == pgood_comp[0]
        && $past(pgood_comp[0], 2) == pgood_comp[0] && $past(pgood_comp[0]) == pgood_comp[0]
        |-> avs_readdata[0] == pgood_comp[0]) else $error("power-good read wrong");
    fault_quiet_a: assert property (fault_comp == '0 && $past(fault_comp) == '0
        && $past(fault_comp, 2) == '0 && $past(fault_comp, 3) == '0 |-> !fault_irq)
        else $error("interrupt without fault");
    disch_off_a: assert property ((ldo_discharge & ldo_enable) == '0)
        else $error("discharge while regulator on");
    ctrl_write_a: assert property (ans && avs_write
        && avs_address == `LDORC_ADDR_A_CTRL && avs_byteenable[0]
        |=> ##1 ldo_enable[0] == $past(avs_writedata[7], 2)
        && ldo_low_iq[0] == $past(avs_writedata[5], 2)
        && ldo_delay_code[2:0] == $past(avs_writedata[4:2], 2)) else $error("control write lost");
    volt_write_a: assert property (ans && avs_write && avs_address == `LDORC_ADDR_B_VOLT
        && avs_byteenable[0] |=> ##1 ldo_voltage_code[11:6] == $past(avs_writedata[5:0], 2))
        else $error("voltage write lost");
    ////////////////////////////////////////////////////////////////////////
    cover property (ans && avs_write && mapped);
    cover property (ans && !mapped);
    cover property (fault_irq);
    cover property (ldo_discharge != '0);
endmodule
bind ldorc_regs ldorc_regs_properties chk (.clk_sys, .rst_n, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
    .avs_response_err, .pgood_comp, .fault_comp, .ldo_enable, .ldo_discharge, .ldo_low_iq,
    .ldo_delay_code, .ldo_voltage_code, .fault_irq);
`default_nettype wire

// file: tb/ldorc_regs_test.sv
// self-checking bench for the regulator register bank
`timescale 1ns/1ps
`default_nettype none
`include "ldorc_params.svh"
module ldorc_regs_test;
    import ldorc_pkg::*;
    logic           clk_sys = 1'b0;
    logic           rst_n = 1'b0;
    ldorc_addr_t    avs_address = '0;
    logic           avs_read = 1'b0;
    logic           avs_write = 1'b0;
    ldorc_data_t    avs_writedata = '0;
    logic [3:0]     avs_byteenable = 4'h0;
    ldorc_data_t    avs_readdata;
    logic           avs_waitrequest;
    logic           avs_response_err;
    ldorc_chvec_t   pgood_comp = '0;
    ldorc_chvec_t   fault_comp = '0;
    ldorc_chvec_t   ldo_enable;
    ldorc_chvec_t   ldo_discharge;
    ldorc_chvec_t   ldo_low_iq;
    logic [8:0]     ldo_delay_code;
    logic [17:0]    ldo_voltage_code;
    logic           fault_irq;
    int             fails = 0;
    int             total_checks = 0;
    int             cycles = 0;
    int             sel;
    logic [31:0]    lfsrState = 32'hb522c248;
    logic [7:0]     regs [6];
    logic [31:0]    rdData;
    logic           rdErr;
    ldorc_addr_t    addr;
    logic [3:0]     be;
    ldorc_addr_t    addrTab [6] = '{`LDORC_ADDR_A_VOLT, `LDORC_ADDR_A_CTRL,
        `LDORC_ADDR_B_VOLT, `LDORC_ADDR_B_CTRL, `LDORC_ADDR_C_VOLT, `LDORC_ADDR_C_CTRL};
    always #2 clk_sys = ~clk_sys;
    ldorc_regs uut (.clk_sys, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable, .avs_readdata, .avs_waitrequest, .avs_response_err, .pgood_comp,
        .fault_comp, .ldo_enable, .ldo_discharge, .ldo_low_iq, .ldo_delay_code,
        .ldo_voltage_code, .fault_irq);
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsrStep(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // odd table slots are control registers; bit 0 is live status
    function automatic logic [31:0] expRead(input int i);
        return i[0] ? {24'h0, regs[i][7:1], pgood_comp[i/2]} : {26'h0, regs[i][5:0]};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic summarize();
        $display("checks=%0d mismatches=%0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // holds the request until waitrequest is sampled low
    task automatic busXfer(input logic wr, input ldorc_addr_t a, input logic [7:0] d,
                           input logic [3:0] bel);
        int n;
        n = 0;
        @(posedge clk_sys);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= {lfsrState[31:8], d};
        avs_byteenable <= bel;
        // no cycle limit here; if waitrequest stays high only the bench timeout ends this wait
        do begin
            @(posedge clk_sys);
            n++;
        end while (avs_waitrequest !== 1'b0);
        // one wait state: answer seen at the second edge after the request
        chk(32'(n), 32'h2);
        rdData = avs_readdata;
        rdErr = avs_response_err;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic chkPorts();
        logic [2:0]  fen;
        logic [31:0] got;
        logic [31:0] want;
        for (int c = 0; c < 3; c++) begin
            fen[c] = regs[2*c+1][1];
            got = 32'({ldo_enable[c], ldo_discharge[c], ldo_low_iq[c], ldo_delay_code[3*c+:3],
                ldo_voltage_code[6*c+:6]});
            want = 32'({regs[2*c+1][7], regs[2*c+1][6] & ~regs[2*c+1][7], regs[2*c+1][5:2],
                regs[2*c][5:0]});
            chk(got, want);
        end
        chk(32'(fault_irq), 32'(|(fen & fault_comp)));
    endtask
    ////////////////////////////////////////////////////////////////////////
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 5000) begin
            fails++;
            summarize();
        end
    end
    initial begin
        repeat (8) @(posedge clk_sys);
        rst_n <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            busXfer(1'b0, addrTab[i], 8'h00, 4'hf);
            chk(rdData, 32'h0);
            busXfer(1'b1, addrTab[i], 8'hff, 4'h1);
            regs[i] = i[0] ? 8'hfe : 8'h3f;
            busXfer(1'b0, addrTab[i], 8'h00, 4'hf);
            chk(rdData, expRead(i));
        end
        for (int k = 0; k < 60; k++) begin
            lfsrState = lfsrStep(lfsrState);
            sel = int'(lfsrState[2:0]);
            // 0x56 sits next to a mapped pair; the upper half is never mapped
            addr = sel < 6 ? addrTab[sel] : (sel == 6 ? 8'h56 : {1'b1, lfsrState[14:8]});
            be = lfsrState[19:16] | {3'h0, lfsrState[20] | lfsrState[21]};
            busXfer(1'b1, addr, lfsrState[31:24], be);
            chk(32'(rdErr), 32'(sel >= 6));
            if (sel < 6 && be[0]) begin
                regs[sel] = lfsrState[31:24] & (sel[0] ? 8'hfe : 8'h3f);
            end
            pgood_comp <= lfsrState[24:22];
            fault_comp <= lfsrState[27:25];
            repeat (5) @(posedge clk_sys);
            chkPorts();
            busXfer(1'b0, addr, 8'h00, 4'hf);
            chk(rdData, sel < 6 ? expRead(sel) : 32'h0);
            chk(32'(rdErr), 32'(sel >= 6));
        end
        summarize();
    end
endmodule
`default_nettype wire
